// file: dsl_logger.sv
// service-data logger: lifetime counters, data log, fault log, APB slave
`timescale 1ns/1ps
`include "dsl_cfg.svh"
module dsl_logger #(
  parameter logic [31:0] SAMPLE_CYC = 32'(`DSL_SAMPLE_CYC),
  parameter logic [31:0] TENTH_CYC = 32'(`DSL_TENTH_CYC)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_cut_in,
  input wire logic supply_loss,
  input wire logic heatsink_overtemp,
  input wire logic dc_overvolt,
  input wire logic alarm7_active,
  input wire logic motor_running,
  input wire logic start_cmd,
  input wire logic trip,
  input wire logic [6:0] trip_code,
  input wire logic [13:0] trip_value,
  input wire logic term16,
  input wire logic term17,
  input wire logic term18,
  input wire logic term19,
  input wire logic term27,
  input wire logic term29,
  input wire logic term32,
  input wire logic term33,
  input wire logic [15:0] status_word,
  input wire logic [6:0] reference_pct,
  input wire logic [15:0] feedback,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] out_volt,
  input wire logic [15:0] out_curr,
  input wire logic [15:0] link_volt,
  input wire logic [15:0] power_kw,
  input wire logic keypad_ok,
  input wire logic energy_clear_request,
  input wire logic runhour_clear_request,
  input wire logic manual_init,
  input wire logic [7:0] disp_addr,
  input wire logic [4:0] disp_log_index,
  input wire logic [3:0] disp_fault_index,
  output logic [31:0] disp_data,
  output logic persist_strobe,
  output logic logging_active
);
  logic mr_q;
  logic motor_stop;
  logic tenth_tick;
  logic hour_tick;
  logic [31:0] tenth_cnt;
  logic [3:0] tenth_n;
  logic [20:0] oper_hours;
  logic [20:0] run_hours;
  logic [19:0] power_acc;
  logic [31:0] output_energy_total;
  logic [13:0] cut_in_count;
  logic [13:0] overtemp_count;
  logic [13:0] overvolt_count;
  logic [15:0] ctrl_word;
  logic [4:0] log_index;
  logic [3:0] fault_index;
  logic [4:0] wr_ptr;
  logic [4:0] log_count;
  logic [3:0] fault_count;
  logic [31:0] sample_cnt;
  logic log_wr;
  logic wr_en;
  logic next_err;
  dsl_pkg::dsl_state_t log_state;
  dsl_pkg::dsl_log_entry_t next_entry;
  dsl_pkg::dsl_log_entry_t log_mem [0:`DSL_LOG_DEPTH-1];
  dsl_pkg::dsl_fault_t fault_mem [0:`DSL_FAULT_DEPTH-1];

  function automatic logic [13:0] sat_inc(input logic [13:0] v);
    sat_inc = (v == `DSL_EVENT_MAX) ? v : v + 14'h0001;
  endfunction

  function automatic logic [20:0] hour_inc(input logic [20:0] v);
    hour_inc = (v == `DSL_HOURS_MAX) ? v : v + 21'h0_0001;
  endfunction

  // index 1 is the slot just behind the write pointer
  function automatic logic [4:0] log_slot(input logic [4:0] idx);
    logic [5:0] s;
    s = {1'b0, wr_ptr} + {1'b0, `DSL_LOG_DEPTH} - {1'b0, idx};
    if (s >= {1'b0, `DSL_LOG_DEPTH}) begin
      s = s - {1'b0, `DSL_LOG_DEPTH};
    end
    log_slot = s[4:0];
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= `DSL_OFF_ECLR);
  endfunction

  function automatic logic writable(input logic [7:0] a);
    writable = (a == `DSL_OFF_CTRL) || (a == `DSL_OFF_LOGIDX) ||
               (a == `DSL_OFF_FLTIDX);
  endfunction

  // shared by the serial bus and the display port
  function automatic logic [31:0] read_word(
    input logic [7:0] a,
    input logic [4:0] li,
    input logic [3:0] fi
  );
    dsl_pkg::dsl_log_entry_t le;
    dsl_pkg::dsl_fault_t fe;
    le = '0;
    fe = '0;
    read_word = 32'h0000_0000;
    if (li != 5'h00 && li <= log_count) begin
      le = log_mem[log_slot(li)];
    end
    if (fi != 4'h0 && fi <= fault_count) begin
      fe = fault_mem[fi - 4'h1];
    end
    if (a == `DSL_OFF_OPER) begin
      read_word = 32'(oper_hours);
    end else if (a == `DSL_OFF_RUN) begin
      read_word = 32'(run_hours);
    end else if (a == `DSL_OFF_ENERGY) begin
      read_word = output_energy_total;
    end else if (a == `DSL_OFF_CUTIN) begin
      read_word = 32'(cut_in_count);
    end else if (a == `DSL_OFF_OTEMP) begin
      read_word = 32'(overtemp_count);
    end else if (a == `DSL_OFF_OVOLT) begin
      read_word = 32'(overvolt_count);
    end else if (a == `DSL_OFF_CTRL) begin
      read_word = 32'(ctrl_word);
    end else if (a == `DSL_OFF_LOGIDX) begin
      read_word = 32'(log_index);
    end else if (a == `DSL_OFF_LOGIN) begin
      read_word = 32'(le.logged_input_byte);
    end else if (a == `DSL_OFF_LOGCTL) begin
      read_word = 32'(le.ctrl);
    end else if (a == `DSL_OFF_LOGSTAT) begin
      read_word = 32'(le.logged_status_word);
    end else if (a == `DSL_OFF_LOGREF) begin
      read_word = 32'(le.ref_pct);
    end else if (a == `DSL_OFF_LOGFB) begin
      read_word = 32'(le.fdbk);
    end else if (a == `DSL_OFF_LOGFRQ) begin
      read_word = 32'(le.freq);
    end else if (a == `DSL_OFF_LOGVOLT) begin
      read_word = 32'(le.volt);
    end else if (a == `DSL_OFF_LOGCUR) begin
      read_word = 32'(le.curr);
    end else if (a == `DSL_OFF_LOGLINK) begin
      read_word = 32'(le.logged_link_voltage);
    end else if (a == `DSL_OFF_FLTIDX) begin
      read_word = 32'(fault_index);
    end else if (a == `DSL_OFF_FLTCODE) begin
      read_word = 32'(fe.code);
    end else if (a == `DSL_OFF_FLTTIME) begin
      read_word = 32'(fe.hours);
    end else if (a == `DSL_OFF_FLTVAL) begin
      read_word = 32'(fe.value);
    end else if (a == `DSL_OFF_STATUS) begin
      read_word = 32'({fault_count, log_count, log_state == dsl_pkg::dsl_logging});
    end
  endfunction

  // bus slave: data and error are fixed in the setup cycle, zero wait states
  assign next_err = !addr_ok(paddr) || (paddr == `DSL_OFF_ECLR) ||
                    (pwrite && !writable(paddr));
  assign wr_en = psel && penable && pready && pwrite && !pslverr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        pslverr <= next_err;
        prdata <= (pwrite || next_err) ? 32'h0000_0000 :
                  read_word(paddr, log_index, fault_index);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_word <= 16'h0000;
      log_index <= `DSL_LOGIDX_RST;
      fault_index <= `DSL_FLTIDX_RST;
    end else if (wr_en) begin
      if (paddr == `DSL_OFF_CTRL) begin
        ctrl_word <= pwdata[15:0];
      end else if (paddr == `DSL_OFF_LOGIDX) begin
        log_index <= pwdata[4:0];
      end else if (paddr == `DSL_OFF_FLTIDX) begin
        fault_index <= pwdata[3:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_data <= 32'h0000_0000;
    end else begin
      disp_data <= read_word(disp_addr, disp_log_index, disp_fault_index);
    end
  end

  // time base: one pulse per tenth of an hour, hour pulse with the tenth one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tenth_cnt <= 32'h0000_0000;
      tenth_n <= 4'h0;
      tenth_tick <= 1'b0;
      hour_tick <= 1'b0;
    end else begin
      tenth_tick <= 1'b0;
      hour_tick <= 1'b0;
      if (tenth_cnt == TENTH_CYC - 32'h0000_0001) begin
        tenth_cnt <= 32'h0000_0000;
        tenth_tick <= 1'b1;
        if (tenth_n == `DSL_TENTHS_PER_HOUR - 4'h1) begin
          tenth_n <= 4'h0;
          hour_tick <= 1'b1;
        end else begin
          tenth_n <= tenth_n + 4'h1;
        end
      end else begin
        tenth_cnt <= tenth_cnt + 32'h0000_0001;
      end
    end
  end

  // the store outside saves the hour counters on this strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      persist_strobe <= 1'b0;
    end else begin
      persist_strobe <= hour_tick || supply_loss;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oper_hours <= 21'h0_0000;
    end else if (tenth_tick) begin
      oper_hours <= hour_inc(oper_hours);
    end
  end

  // run time is sampled at each tenth tick, so a run shorter than that may be missed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_hours <= 21'h0_0000;
    end else if (keypad_ok && runhour_clear_request == `DSL_SEL_CLEAR) begin
      run_hours <= 21'h0_0000;
    end else if (tenth_tick && motor_running) begin
      run_hours <= hour_inc(run_hours);
    end
  end

  // ten power samples per hour; their mean is that hour's energy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_acc <= 20'h0_0000;
      output_energy_total <= 32'h0000_0000;
    end else begin
      if (tenth_tick) begin
        if (hour_tick) begin
          power_acc <= 20'h0_0000;
          output_energy_total <= output_energy_total +
            32'((power_acc + 20'(power_kw)) / 20'h0_000A);
        end else begin
          power_acc <= power_acc + 20'(power_kw);
        end
      end
      if (keypad_ok && energy_clear_request == `DSL_SEL_CLEAR) begin
        output_energy_total <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cut_in_count <= 14'h0000;
      overtemp_count <= 14'h0000;
      overvolt_count <= 14'h0000;
    end else begin
      if (supply_cut_in) begin
        cut_in_count <= sat_inc(cut_in_count);
      end
      if (heatsink_overtemp) begin
        overtemp_count <= sat_inc(overtemp_count);
      end
      if (dc_overvolt && alarm7_active) begin
        overvolt_count <= sat_inc(overvolt_count);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mr_q <= 1'b0;
    end else begin
      mr_q <= motor_running;
    end
  end
  assign motor_stop = mr_q && !motor_running;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_state <= dsl_pkg::dsl_idle;
      logging_active <= 1'b0;
    end else begin
      case (log_state)
        dsl_pkg::dsl_idle: begin
          if (start_cmd && !trip) begin
            log_state <= dsl_pkg::dsl_logging;
            logging_active <= 1'b1;
          end
        end
        default: begin
          if (trip || motor_stop) begin
            log_state <= dsl_pkg::dsl_idle;
            logging_active <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_cnt <= 32'h0000_0000;
    end else if (log_state != dsl_pkg::dsl_logging || log_wr) begin
      sample_cnt <= 32'h0000_0000;
    end else begin
      sample_cnt <= sample_cnt + 32'h0000_0001;
    end
  end

  // a trip or stop in the sampling cycle wins, so the frozen log is pre-trip
  assign log_wr = (log_state == dsl_pkg::dsl_logging) && !trip && !motor_stop &&
                  (sample_cnt == SAMPLE_CYC - 32'h0000_0001);

  always_comb begin
    next_entry.logged_input_byte = {term16, term17, term18, term19,
                                    term27, term29, term32, term33};
    next_entry.ctrl = ctrl_word;
    next_entry.logged_status_word = status_word;
    next_entry.ref_pct = reference_pct;
    next_entry.fdbk = feedback;
    next_entry.freq = out_freq;
    next_entry.volt = out_volt;
    next_entry.curr = out_curr;
    next_entry.logged_link_voltage = link_volt;
  end

  // log contents need no reset: slots beyond the fill count read as zero
  always_ff @(posedge pclk) begin
    if (log_wr) begin
      log_mem[wr_ptr] <= next_entry;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= 5'h00;
      log_count <= 5'h00;
    end else if (log_wr) begin
      wr_ptr <= (wr_ptr == `DSL_LOG_DEPTH - 5'h01) ? 5'h00 : wr_ptr + 5'h01;
      if (log_count != `DSL_LOG_DEPTH) begin
        log_count <= log_count + 5'h01;
      end
    end
  end

  // a trip in the same cycle as initialisation is still recorded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_count <= 4'h0;
      for (int i = 0; i < `DSL_FAULT_DEPTH; i++) begin
        fault_mem[i] <= '0;
      end
    end else begin
      if (manual_init) begin
        fault_count <= 4'h0;
        for (int i = 0; i < `DSL_FAULT_DEPTH; i++) begin
          fault_mem[i] <= '0;
        end
      end
      if (trip) begin
        for (int i = `DSL_FAULT_DEPTH - 1; i > 0; i--) begin
          fault_mem[i] <= fault_mem[i-1];
        end
        fault_mem[0] <= {trip_code, run_hours, trip_value};
        if (manual_init) begin
          fault_count <= 4'h1;
        end else if (fault_count != `DSL_FAULT_DEPTH) begin
          fault_count <= fault_count + 4'h1;
        end
      end
    end
  end

  default clocking dsl_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  oper_ceiling_a: assert property (
    oper_hours <= `DSL_HOURS_MAX)
    else $error("operating hours above ceiling");
  oper_step_a: assert property (
    tenth_tick && oper_hours != `DSL_HOURS_MAX |=> oper_hours == $past(oper_hours) + 21'h0_0001)
    else $error("operating hours did not advance");
  run_step_a: assert property (
    tenth_tick && motor_running && !keypad_ok && run_hours != `DSL_HOURS_MAX |=>
      run_hours == $past(run_hours) + 21'h0_0001)
    else $error("run hours did not advance");
  run_clear_a: assert property (
    keypad_ok && runhour_clear_request |=> run_hours == 21'h0_0000)
    else $error("run hours not cleared");
  energy_clear_a: assert property (
    keypad_ok && energy_clear_request |=> output_energy_total == 32'h0000_0000)
    else $error("energy total not cleared");
  overvolt_gate_a: assert property (
    !alarm7_active |=> overvolt_count == $past(overvolt_count))
    else $error("overvoltage counted without alarm");
  cutin_sat_a: assert property (
    cut_in_count == `DSL_EVENT_MAX |=> cut_in_count == `DSL_EVENT_MAX)
    else $error("cut-in counter wrapped");
  log_fill_a: assert property (
    log_wr && log_count != `DSL_LOG_DEPTH |=> log_count == $past(log_count) + 5'h01)
    else $error("log count did not grow");
  log_freeze_a: assert property (
    trip |=> !logging_active ##0 !log_wr [*2])
    else $error("logging went on after trip");
  fault_push_a: assert property (
    trip |=> fault_mem[0].code == $past(trip_code) && fault_mem[0].hours == $past(run_hours))
    else $error("trip not recorded newest first");
  fault_keep_a: assert property (
    !manual_init && fault_count != 4'h0 |=> fault_count != 4'h0)
    else $error("fault history lost without initialisation");
  eclr_refuse_a: assert property (
    psel && !penable && paddr == `DSL_OFF_ECLR |=> pslverr && prdata == 32'h0000_0000)
    else $error("energy-clear selection reachable from bus");
  ctrl_write_a: assert property (
    wr_en && paddr == `DSL_OFF_CTRL |=> ctrl_word == $past(pwdata[15:0]))
    else $error("control word write lost");

  log_wrap_c: cover property (log_wr && log_count == `DSL_LOG_DEPTH);
  trip_run_c: cover property (trip && logging_active);
  energy_clr_c: cover property (keypad_ok && energy_clear_request);
  fault_full_c: cover property (trip && fault_count == `DSL_FAULT_DEPTH);
endmodule

// file: dsl_cfg.svh
// register map, limits and timing of the service-data logger
// Function
// - count powered hours to 130,000.0, save hourly and at supply loss, never clear
// - count motor run hours since last clear, save hourly and at supply loss
// - total output energy in kWh from hourly mean power, clear only by request
// - count supply cut-ins, 0 to 9999
// - count heat-sink overtemperature errors, 0 to 9999
// - count DC-link overvoltages, 0 to 9999, only while alarm 7 active
// - rolling 20-entry data log, index 1 newest, index 20 oldest
// - after a start command append a data-log entry every 160 ms
// - on trip or motor stop, stop logging and keep last 20 entries
// - log digital inputs as one byte, terminal 16 MSB down to 33 LSB
// - log control and status words as 16-bit unsigned values
// - control word is changed only from the serial port
// - entries also hold reference, feedback, frequency, voltage, current, link voltage
// - keep 10 trip cause codes 0 to 99, index 1 newest
// - keep run-hour count at each of the last 10 trips
// - keep the measured value 0 to 9999 at each logged trip
// - trip history is cleared only by manual initialisation
// - energy-clear selection 1 confirmed by OK zeroes the energy total
// - energy-clear selection refused from the serial port, keypad only
// - counters and log readable from local display and serial port
// - run-hour clear selection 1 with OK zeroes run hours, keypad only
`ifndef DSL_CFG_SVH
`define DSL_CFG_SVH
`define DSL_HOURS_MAX 21'h13_D620
`define DSL_EVENT_MAX 14'h270F
`define DSL_LOG_DEPTH 5'h14
`define DSL_FAULT_DEPTH 4'hA
`define DSL_TENTHS_PER_HOUR 4'hA
`define DSL_SEL_CLEAR 1'h1
`define DSL_CLK_HZ 64'h0000_0000_0098_9680
`define DSL_SAMPLE_MS 64'h0000_0000_0000_00A0
`define DSL_TENTH_S 64'h0000_0000_0000_0168
`define DSL_SAMPLE_CYC (`DSL_SAMPLE_MS * `DSL_CLK_HZ / 64'h0000_0000_0000_03E8)
`define DSL_TENTH_CYC (`DSL_TENTH_S * `DSL_CLK_HZ)
`define DSL_OFF_OPER 8'h00
`define DSL_OFF_RUN 8'h04
`define DSL_OFF_ENERGY 8'h08
`define DSL_OFF_CUTIN 8'h0C
`define DSL_OFF_OTEMP 8'h10
`define DSL_OFF_OVOLT 8'h14
`define DSL_OFF_CTRL 8'h18
`define DSL_OFF_LOGIDX 8'h1C
`define DSL_OFF_LOGIN 8'h20
`define DSL_OFF_LOGCTL 8'h24
`define DSL_OFF_LOGSTAT 8'h28
`define DSL_OFF_LOGREF 8'h2C
`define DSL_OFF_LOGFB 8'h30
`define DSL_OFF_LOGFRQ 8'h34
`define DSL_OFF_LOGVOLT 8'h38
`define DSL_OFF_LOGCUR 8'h3C
`define DSL_OFF_LOGLINK 8'h40
`define DSL_OFF_FLTIDX 8'h44
`define DSL_OFF_FLTCODE 8'h48
`define DSL_OFF_FLTTIME 8'h4C
`define DSL_OFF_FLTVAL 8'h50
`define DSL_OFF_STATUS 8'h54
`define DSL_OFF_ECLR 8'h58
`define DSL_LOGIDX_RST 5'h01
`define DSL_FLTIDX_RST 4'h1
`endif

// file: dsl_pkg.sv
// types of the service-data logger
package dsl_pkg;
  typedef enum logic [0:0] {dsl_idle, dsl_logging} dsl_state_t;
  typedef struct packed {
    logic [7:0] logged_input_byte;
    logic [15:0] ctrl;
    logic [15:0] logged_status_word;
    logic [6:0] ref_pct;
    logic [15:0] fdbk;
    logic [15:0] freq;
    logic [15:0] volt;
    logic [15:0] curr;
    logic [15:0] logged_link_voltage;
  } dsl_log_entry_t;
  typedef struct packed {
    logic [6:0] code;
    logic [20:0] hours;
    logic [13:0] value;
  } dsl_fault_t;
endpackage

// file: dsl_keypad_model.sv
// keypad and local display model standing at the logger's far side
`timescale 1ns/1ps
module dsl_keypad_model (
  input wire logic pclk,
  output logic keypad_ok,
  output logic energy_clear_request,
  output logic runhour_clear_request,
  output logic [7:0] disp_addr,
  output logic [4:0] disp_log_index,
  output logic [3:0] disp_fault_index,
  input wire logic [31:0] disp_data
);
  initial begin
    keypad_ok = 1'b0;
    energy_clear_request = 1'b0;
    runhour_clear_request = 1'b0;
    disp_addr = 8'h00;
    disp_log_index = 5'h01;
    disp_fault_index = 4'h1;
  end
  // selection is set before and held past the key press, as an operator would
  task automatic press(input logic e, input logic r);
    @(posedge pclk);
    energy_clear_request <= e;
    runhour_clear_request <= r;
    @(posedge pclk);
    keypad_ok <= 1'b1;
    @(posedge pclk);
    keypad_ok <= 1'b0;
    @(posedge pclk);
    energy_clear_request <= 1'b0;
    runhour_clear_request <= 1'b0;
  endtask
  // display data answers one edge after the selector, so sample one edge later
  task automatic show(input logic [7:0] a, output logic [31:0] d);
    @(posedge pclk);
    disp_addr <= a;
    repeat (2) @(posedge pclk);
    d = disp_data;
  endtask
endmodule

// file: tb_dsl_logger.sv
// self-checking testbench of the service-data logger
`timescale 1ns/1ps
module tb_dsl_logger;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic motor_running = 1'b0;
  logic start_cmd = 1'b0;
  logic alarm7_active = 1'b0;
  logic supply_loss = 1'b0;
  logic manual_init = 1'b0;
  logic pready, pslverr, keypad_ok, ecr, rcr, ps, la;
  logic [7:0] paddr = 8'h00;
  logic [7:0] tin = 8'h00;
  logic [7:0] lb, daddr;
  logic [4:0] dli;
  logic [3:0] dfi;
  logic [3:0] evt = 4'h0;
  logic [6:0] trip_code = 7'h00;
  logic [13:0] trip_value = 14'h0000;
  logic [15:0] sw = 16'h0000;
  logic [15:0] pwr = 16'h0000;
  logic [15:0] cw;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, disp_data, rd;
  logic [32:0] q[$];
  integer seed = 32'he3f0_5ab2;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;

  dsl_logger #(.SAMPLE_CYC(32'h0000_0008), .TENTH_CYC(32'h0000_0014)) i_dsl_logger (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_cut_in(evt[0]), .supply_loss(supply_loss), .heatsink_overtemp(evt[1]),
    .dc_overvolt(evt[2]), .alarm7_active(alarm7_active), .motor_running(motor_running),
    .start_cmd(start_cmd), .trip(evt[3]), .trip_code(trip_code), .trip_value(trip_value),
    .term16(tin[7]), .term17(tin[6]), .term18(tin[5]), .term19(tin[4]), .term27(tin[3]),
    .term29(tin[2]), .term32(tin[1]), .term33(tin[0]), .status_word(sw),
    .reference_pct(7'(sw[5:0])), .feedback(sw), .out_freq(sw), .out_volt(sw),
    .out_curr(sw), .link_volt(sw), .power_kw(pwr), .keypad_ok(keypad_ok),
    .energy_clear_request(ecr), .runhour_clear_request(rcr), .manual_init(manual_init),
    .disp_addr(daddr), .disp_log_index(dli), .disp_fault_index(dfi),
    .disp_data(disp_data), .persist_strobe(ps), .logging_active(la));

  dsl_keypad_model i_dsl_keypad_model (
    .pclk(pclk), .keypad_ok(keypad_ok), .energy_clear_request(ecr),
    .runhour_clear_request(rcr), .disp_addr(daddr), .disp_log_index(dli),
    .disp_fault_index(dfi), .disp_data(disp_data));

  always #50 pclk = ~pclk;

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // expected {pslverr, read data} is queued; writes expect data 0
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    // this wait ends when pready is high; only the bench timeout ends it if pready never rises
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ev(input logic [3:0] m, input int n);
    repeat (n) begin
      @(posedge pclk);
      evt <= m;
      @(posedge pclk);
      evt <= 4'h0;
    end
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready && q.size() > 0) begin
      check({pslverr, pwrite ? 32'h0000_0000 : prdata}, q.pop_front());
    end
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    pwr <= 16'($unsigned($random(seed)) % 200);
    apb(0, 8'h00, 0, 33'h0);
    apb(0, 8'h1C, 0, 33'h1);
    apb(1, 8'h58, 32'h1, {1'b1, 32'h0});
    apb(0, 8'h58, 0, {1'b1, 32'h0});
    apb(1, 8'h00, 32'h5, {1'b1, 32'h0});
    apb(0, 8'h5C, 0, {1'b1, 32'h0});
    apb(0, 8'h02, 0, {1'b1, 32'h0});
    cw = 16'($random(seed));
    apb(1, 8'h18, {16'h0000, cw}, 33'h0);
    apb(0, 8'h18, 0, {17'h0, cw});
    // first hour closes near 200 cycles; the second is far enough away
    repeat (220) @(posedge pclk);
    apb(0, 8'h08, 0, {17'h0, pwr});
    i_dsl_keypad_model.press(1'b0, 1'b0);
    apb(0, 8'h08, 0, {17'h0, pwr});
    i_dsl_keypad_model.press(1'b1, 1'b0);
    apb(0, 8'h08, 0, 33'h0);
    ev(4'h1, 3);
    apb(0, 8'h0C, 0, 33'h3);
    ev(4'h2, 2);
    apb(0, 8'h10, 0, 33'h2);
    ev(4'h4, 1);
    alarm7_active <= 1'b1;
    ev(4'h4, 2);
    apb(0, 8'h14, 0, 33'h2);
    @(posedge pclk);
    tin <= 8'($random(seed));
    sw <= 16'($random(seed));
    motor_running <= 1'b1;
    start_cmd <= 1'b1;
    trip_code <= 7'($unsigned($random(seed)) % 100);
    trip_value <= 14'($unsigned($random(seed)) % 10000);
    @(posedge pclk);
    start_cmd <= 1'b0;
    repeat (60) @(posedge pclk);
    check({32'h0, la}, 33'h1);
    ev(4'h8, 1);
    lb = tin;
    tin <= ~tin;
    repeat (30) @(posedge pclk);
    check({32'h0, la}, 33'h0);
    apb(0, 8'h20, 0, {25'h0, lb});
    apb(0, 8'h28, 0, {17'h0, sw});
    apb(0, 8'h40, 0, {17'h0, sw});
    apb(1, 8'h1C, 32'h14, 33'h0);
    apb(0, 8'h20, 0, 33'h0);
    apb(0, 8'h48, 0, {26'h0, trip_code});
    apb(0, 8'h50, 0, {19'h0, trip_value});
    i_dsl_keypad_model.show(8'h0C, rd);
    check({1'b0, rd}, 33'h3);
    motor_running <= 1'b0;
    i_dsl_keypad_model.press(1'b0, 1'b1);
    apb(0, 8'h04, 0, 33'h0);
    supply_loss <= 1'b1;
    @(posedge pclk);
    supply_loss <= 1'b0;
    manual_init <= 1'b1;
    @(posedge pclk);
    // the strobe launched one edge ago still stands at this edge
    check({32'h0, ps}, 33'h1);
    manual_init <= 1'b0;
    apb(0, 8'h48, 0, 33'h0);
    ev(4'h1, 9997);
    apb(0, 8'h0C, 0, 33'h270F);
    tally_and_finish();
  end
endmodule
